// ==== core/ref_pll_defs.svh ====
// register map, field positions, reset values and limits of the pll and input stage block
`ifndef REF_PLL_DEFS_SVH
`define REF_PLL_DEFS_SVH

// register offsets; stage registers at 0x020 + 0x010 * stage
`define OFS_PLL_CTRL 12'h000
`define OFS_PLL_STAT 12'h004
`define STG_PAGE 7'h01
`define SUB_CFG 2'h0
`define SUB_DIV 2'h1
`define SUB_FM_LO 2'h2
`define SUB_FM_HI 2'h3

// pll control and status fields
`define CTRL_FB 9:0
`define CTRL_DBL 16
`define CTRL_ROUTE 17
`define STAT_CLR 2

// stage configuration fields
`define CFG_MODE 1:0
`define CFG_PMOS 2
`define CFG_INV_P 3
`define CFG_INV_N 4
`define CFG_BYP_P 5
`define CFG_BYP_N 6
`define CFG_DIS_P 7
`define CFG_DIS_N 8
`define CFG_SYN_P 9
`define CFG_SYN_N 10
`define CFG_ASSOC 15:12
`define CFG_PIN_EN 16
`define CFG_DIS_PIN 17
`define CFG_INV_PIN 18
`define CFG_SYN_PIN 19

// divider and frequency word fields
`define DIV_P 15:0
`define DIV_N 31:16
`define FM_HI_M 15:0
`define FM_HI_N 31:16

// reset values
`define FB_RST 10'h01c2
`define DIV_RST 32'h0001_0001
`define FM_HI_RST 32'h0001_0000
`define DIV_ONE 16'h0001

// limits and indices
`define FB_MIN 10'h006c
`define FB_MAX 10'h022c
`define LVL_MID 12'h800
`define LOCK_BASE 12'h020
`define LOCK_DBL 12'h020
`define IDX_NEG 4'h8
`define IDX_PIN0 4'h8
`define IDX_PIN3 4'hf
`define MODE_BAD 2'h3
`define RESP_OK 2'h0
`define RESP_ERR 2'h2

`endif

// ==== core/ref_pll_pkg.sv ====
// types shared by the pll and input stage block
package ref_pll_pkg;
   typedef enum logic [1:0] {MODE_DIFF, MODE_DUAL_SE, MODE_DIFF_PIN} in_mode_t;
   typedef enum logic [1:0] {SRC_NONE, SRC_OTP, SRC_EEPROM} boot_src_t;
   typedef enum logic {BOOT_LOAD, BOOT_READY} boot_t;
   typedef struct packed {
      logic [5:0] pin1;
      logic [5:0] pin2;
      logic [5:0] pin3;
      logic [11:0] lvl1;
      logic [11:0] lvl2;
      boot_t boot;
      boot_src_t src;
      logic [9:0] fbdiv;
      logic dbl;
      logic route;
      logic locked;
      logic sticky;
      logic [1:0][19:0] cfg;
      logic [1:0][31:0] div;
      logic [1:0][31:0] fm_lo;
      logic [1:0][31:0] fm_hi;
      logic [3:0][15:0] cnt;
      logic [15:0] clk_edge;
      logic [15:0] sync_edge;
      logic aw_got;
      logic w_got;
      logic [11:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } state_t;
endpackage

// ==== core/ref_pll_cfg.sv ====
// system pll configuration, lock alarm and reference input stages behind axi4-lite
`timescale 1ns/100ps
`default_nettype none
`include "ref_pll_defs.svh"

module ref_pll_cfg (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write channels
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read channels
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // reference pins, per stage positive and negative, pins zero and three
   input wire logic [1:0] ref_p_pin,
   input wire logic [1:0] ref_n_pin,
   input wire logic [1:0] gpio_clk_pin,
   // analog loop control level
   input wire logic [11:0] loop_ctrl_level,
   // configuration stores, same clock
   input wire logic store_busy,
   input wire logic otp_enable,
   input wire logic otp_valid,
   input wire logic [10:0] otp_word,
   input wire logic eeprom_enable,
   input wire logic eeprom_valid,
   input wire logic [10:0] eeprom_word,
   // system pll settings and status
   output logic [9:0] pll_fb_div,
   output logic pll_doubler_en,
   output logic pll_locked,
   output logic pll_loss_alarm,
   output logic gpio_status,
   output logic boot_done,
   output ref_pll_pkg::boot_src_t boot_src,
   // input stage results
   output logic [1:0] rx_bias_pmos,
   output logic [15:0] int_clk_edge,
   output logic [15:0] int_sync_edge,
   output logic [3:0] sync_assoc0,
   output logic [3:0] sync_assoc1,
   output logic [47:0] nominal_m0,
   output logic [15:0] nominal_n0,
   output logic [47:0] nominal_m1,
   output logic [15:0] nominal_n1
);
   import ref_pll_pkg::*;

   // internal index of each path: st0 p, st0 n, st1 p, st1 n, pin0, pin3
   localparam logic [5:0][3:0] IDX = {`IDX_PIN3, `IDX_PIN0, 4'h1 + `IDX_NEG, 4'h1,
      4'h0 + `IDX_NEG, 4'h0};

   state_t st, next_st;
   logic [31:0] ctrl_word, stat_word, rd_word;
   logic [1:0][31:0] cfg_word;
   logic rd_hit;
   logic [5:0] rise, fall, inv, live, syn, sel_edge;
   logic [3:0] byp, div_pulse;
   logic [3:0][15:0] dval;
   logic [11:0] margin;
   logic in_window;

   // byte-lane merge of a write into a register word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // legal feedback divider setting
   function automatic logic fb_ok(input logic [9:0] v);
      return (v >= `FB_MIN) && (v <= `FB_MAX);
   endfunction

   // register words as software sees them
   assign ctrl_word = {14'h0000, st.route, st.dbl, 6'h00, st.fbdiv};
   assign stat_word = {26'h000_0000, st.src, st.boot == BOOT_READY, st.sticky,
      !st.locked, st.locked};
   assign cfg_word[0] = {12'h000, st.cfg[0]};
   assign cfg_word[1] = {12'h000, st.cfg[1]};

   // edge polarity, enable and sync designation per path
   assign rise = st.pin2 & ~st.pin3;
   assign fall = ~st.pin2 & st.pin3;
   assign inv = {st.cfg[1][`CFG_INV_PIN], st.cfg[0][`CFG_INV_PIN], st.cfg[1][`CFG_INV_N],
      st.cfg[1][`CFG_INV_P], st.cfg[0][`CFG_INV_N], st.cfg[0][`CFG_INV_P]};
   assign syn = {st.cfg[1][`CFG_SYN_PIN], st.cfg[0][`CFG_SYN_PIN], st.cfg[1][`CFG_SYN_N],
      st.cfg[1][`CFG_SYN_P], st.cfg[0][`CFG_SYN_N], st.cfg[0][`CFG_SYN_P]};
   // a path is live only if enabled and, except the positive paths and pin three, used by the stage mode
   assign live[0] = !st.cfg[0][`CFG_DIS_P];
   assign live[1] = !st.cfg[0][`CFG_DIS_N] && st.cfg[0][`CFG_MODE] == MODE_DUAL_SE;
   assign live[2] = !st.cfg[1][`CFG_DIS_P];
   assign live[3] = !st.cfg[1][`CFG_DIS_N] && st.cfg[1][`CFG_MODE] == MODE_DUAL_SE;
   assign live[4] = st.cfg[0][`CFG_PIN_EN] && !st.cfg[0][`CFG_DIS_PIN] &&
      st.cfg[0][`CFG_MODE] == MODE_DIFF_PIN;
   assign live[5] = st.cfg[1][`CFG_PIN_EN] && !st.cfg[1][`CFG_DIS_PIN];
   assign sel_edge = ((fall & inv) | (rise & ~inv)) & live;

   // divider settings per divided path
   assign byp = {st.cfg[1][`CFG_BYP_N], st.cfg[1][`CFG_BYP_P], st.cfg[0][`CFG_BYP_N],
      st.cfg[0][`CFG_BYP_P]};
   assign dval = {st.div[1][`DIV_N], st.div[1][`DIV_P], st.div[0][`DIV_N], st.div[0][`DIV_P]};

   // lock window follows divider and doubler settings
   assign margin = `LOCK_BASE + {4'h0, st.fbdiv[9:2]} + (st.dbl ? `LOCK_DBL : 12'h000);
   assign in_window = (st.lvl2 >= `LVL_MID - margin) && (st.lvl2 <= `LVL_MID + margin);

   // read decode of the register map
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      if ({araddr[11:2], 2'b00} == `OFS_PLL_CTRL) begin
         rd_word = ctrl_word;
      end else if ({araddr[11:2], 2'b00} == `OFS_PLL_STAT) begin
         rd_word = stat_word;
      end else if (araddr[11:5] == `STG_PAGE) begin
         unique case (araddr[3:2])
            `SUB_CFG: rd_word = cfg_word[araddr[4]];
            `SUB_DIV: rd_word = st.div[araddr[4]];
            `SUB_FM_LO: rd_word = st.fm_lo[araddr[4]];
            `SUB_FM_HI: rd_word = st.fm_hi[araddr[4]];
         endcase
      end else begin
         rd_hit = 1'b0;
      end
   end

   // next state of the whole block
   always_comb begin
      logic [31:0] v;
      logic [11:0] wa;
      logic ws;
      logic clr;
      logic [5:0] fin;
      v = 32'h0000_0000;
      wa = {st.waddr[11:2], 2'b00};
      ws = st.waddr[4];
      clr = 1'b0;
      fin = 6'h00;
      next_st = st;
      // pin and level synchronisers, then edge history
      next_st.pin1 = {gpio_clk_pin, ref_n_pin[1], ref_p_pin[1], ref_n_pin[0], ref_p_pin[0]};
      next_st.pin2 = st.pin1;
      next_st.pin3 = st.pin2;
      next_st.lvl1 = loop_ctrl_level;
      next_st.lvl2 = st.lvl1;
      next_st.locked = in_window;

      // pre-dividers; a dead path holds its count at zero
      for (int i = 0; i < 4; i++) begin
         div_pulse[i] = 1'b0;
         if (!live[i]) begin
            next_st.cnt[i] = 16'h0000;
         end else if (sel_edge[i]) begin
            if (byp[i]) begin
               div_pulse[i] = 1'b1;
            end else if (st.cnt[i] >= dval[i]) begin
               div_pulse[i] = 1'b1;
               next_st.cnt[i] = 16'h0000;
            end else begin
               next_st.cnt[i] = st.cnt[i] + 16'h0001;
            end
         end
      end

      // pin paths bypass every divider; kept local to avoid a loop through a net
      fin = {sel_edge[5:4], div_pulse};

      // route each path to its internal index, as clock or sync
      next_st.clk_edge = 16'h0000;
      next_st.sync_edge = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         if (fin[i] && syn[i]) begin
            next_st.sync_edge[IDX[i]] = 1'b1;
         end else if (fin[i]) begin
            next_st.clk_edge[IDX[i]] = 1'b1;
         end
      end

      // reset sequence: load pll control from a valid store
      unique case (st.boot)
         BOOT_LOAD: begin
            if (!store_busy) begin
               next_st.boot = BOOT_READY;
               if (otp_enable && otp_valid && fb_ok(otp_word[9:0])) begin
                  next_st.fbdiv = otp_word[9:0];
                  next_st.dbl = otp_word[10];
                  next_st.src = SRC_OTP;
               end else if (eeprom_enable && eeprom_valid && fb_ok(eeprom_word[9:0])) begin
                  next_st.fbdiv = eeprom_word[9:0];
                  next_st.dbl = eeprom_word[10];
                  next_st.src = SRC_EEPROM;
               end
            end
         end
         BOOT_READY: begin
         end
      endcase

      // write address and data taken in either order
      if (awvalid && awready) begin
         next_st.aw_got = 1'b1;
         next_st.waddr = awaddr;
      end
      if (wvalid && wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = wdata;
         next_st.wstrb = wstrb;
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end

      // register write once both halves are held
      if (st.aw_got && st.w_got) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = `RESP_OK;
         if (wa == `OFS_PLL_CTRL) begin
            v = merge(ctrl_word, st.wdata, st.wstrb);
            if (st.boot != BOOT_READY) begin
               next_st.bresp = `RESP_ERR;
            end else begin
               if (fb_ok(v[`CTRL_FB])) begin
                  next_st.fbdiv = v[`CTRL_FB];
               end
               next_st.dbl = v[`CTRL_DBL];
               next_st.route = v[`CTRL_ROUTE];
            end
         end else if (wa == `OFS_PLL_STAT) begin
            clr = st.wdata[`STAT_CLR] && st.wstrb[0];
         end else if (st.waddr[11:5] == `STG_PAGE) begin
            unique case (st.waddr[3:2])
               `SUB_CFG: begin
                  v = merge(cfg_word[ws], st.wdata, st.wstrb);
                  // illegal mode codes keep the previous mode
                  if (v[`CFG_MODE] == `MODE_BAD || (ws && v[`CFG_MODE] == MODE_DIFF_PIN)) begin
                     v[`CFG_MODE] = st.cfg[ws][`CFG_MODE];
                  end
                  next_st.cfg[ws] = v[19:0];
               end
               `SUB_DIV: begin
                  v = merge(st.div[ws], st.wdata, st.wstrb);
                  // zero would divide by one; smallest ratio is two
                  if (v[`DIV_P] == 16'h0000) begin
                     v[`DIV_P] = `DIV_ONE;
                  end
                  if (v[`DIV_N] == 16'h0000) begin
                     v[`DIV_N] = `DIV_ONE;
                  end
                  next_st.div[ws] = v;
               end
               `SUB_FM_LO: next_st.fm_lo[ws] = merge(st.fm_lo[ws], st.wdata, st.wstrb);
               `SUB_FM_HI: next_st.fm_hi[ws] = merge(st.fm_hi[ws], st.wdata, st.wstrb);
            endcase
         end else begin
            next_st.bresp = `RESP_ERR;
         end
      end
      // sticky loss alarm; a new loss wins over the clear
      next_st.sticky = (st.sticky && !clr) || !st.locked;

      // read answer
      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_word;
         next_st.rresp = rd_hit ? `RESP_OK : `RESP_ERR;
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.boot <= BOOT_LOAD;
         st.src <= SRC_NONE;
         st.fbdiv <= `FB_RST;
         st.div <= {`DIV_RST, `DIV_RST};
         st.fm_hi <= {`FM_HI_RST, `FM_HI_RST};
      end else begin
         st <= next_st;
      end
   end

   // bus handshakes
   assign awready = !st.aw_got && !st.bvalid;
   assign wready = !st.w_got && !st.bvalid;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign arready = !st.rvalid;
   assign rvalid = st.rvalid;
   assign rdata = st.rdata;
   assign rresp = st.rresp;

   // pll and stage outputs
   assign pll_fb_div = st.fbdiv;
   assign pll_doubler_en = st.dbl;
   assign pll_locked = st.locked;
   assign pll_loss_alarm = !st.locked;
   assign gpio_status = st.route && !st.locked;
   assign boot_done = st.boot == BOOT_READY;
   assign boot_src = st.src;
   assign rx_bias_pmos[0] = st.cfg[0][`CFG_PMOS] && st.cfg[0][`CFG_MODE] != MODE_DUAL_SE;
   assign rx_bias_pmos[1] = st.cfg[1][`CFG_PMOS] && st.cfg[1][`CFG_MODE] != MODE_DUAL_SE;
   assign int_clk_edge = st.clk_edge;
   assign int_sync_edge = st.sync_edge;
   assign sync_assoc0 = st.cfg[0][`CFG_ASSOC];
   assign sync_assoc1 = st.cfg[1][`CFG_ASSOC];
   assign nominal_m0 = {st.fm_hi[0][`FM_HI_M], st.fm_lo[0]};
   assign nominal_n0 = st.fm_hi[0][`FM_HI_N];
   assign nominal_m1 = {st.fm_hi[1][`FM_HI_M], st.fm_lo[1]};
   assign nominal_n1 = st.fm_hi[1][`FM_HI_N];

   // checks on the block's own behaviour
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_ctrl_write;
      st.aw_got && st.w_got && {st.waddr[11:2], 2'b00} == `OFS_PLL_CTRL && st.wstrb == 4'hf;
   endsequence
   sequence s_otp_load;
      st.boot == BOOT_LOAD && !store_busy && otp_enable && otp_valid && fb_ok(otp_word[9:0]);
   endsequence
   sequence s_diff_only;
      st.cfg[0][`CFG_MODE] == MODE_DIFF;
   endsequence

   a_fb_range: assert property (fb_ok(st.fbdiv))
      else $error("feedback divider left its range");
   a_ctrl_rewrite: assert property (s_ctrl_write ##0 boot_done ##0 fb_ok(st.wdata[9:0])
      |=> st.fbdiv == $past(st.wdata[9:0]) && st.dbl == $past(st.wdata[16]) && bvalid)
      else $error("pll control rewrite not applied");
   a_early_refuse: assert property (s_ctrl_write ##0 !boot_done |=> bresp == `RESP_ERR)
      else $error("pll write before boot not refused");
   a_boot_load: assert property (s_otp_load |=> st.fbdiv == $past(otp_word[9:0]) &&
      st.src == SRC_OTP && boot_done)
      else $error("otp contents not loaded at boot");
   a_lock_calc: assert property (in_window |=> pll_locked ##1 !pll_loss_alarm || !$past(in_window))
      else $error("lock state not following window");
   a_loss_sticky: assert property (pll_loss_alarm |=> st.sticky [*1])
      else $error("loss of lock not latched");
   a_dis_quiet: assert property (st.cfg[0][`CFG_DIS_P] |=> !int_clk_edge[0] && !int_sync_edge[0])
      else $error("disabled input produced an edge");
   a_bypass_pass: assert property (sel_edge[0] && byp[0] && !syn[0] |=> int_clk_edge[0])
      else $error("bypassed edge not passed");
   a_div_count: assert property (sel_edge[0] && !byp[0] && st.cnt[0] < dval[0]
      |=> !int_clk_edge[0] && st.cnt[0] == $past(st.cnt[0]) + 16'h0001)
      else $error("divider counted wrongly");
   a_neg_index: assert property (s_diff_only |=> !int_clk_edge[8] && !int_sync_edge[8])
      else $error("index eight active in differential mode");
   a_pin_direct: assert property (sel_edge[5] && !syn[5] |=> int_clk_edge[15])
      else $error("pin three edge not passed to index fifteen");
   a_pin_stage: assert property (st.cfg[1][`CFG_MODE] != MODE_DIFF_PIN &&
      st.cfg[1][`CFG_MODE] != `MODE_BAD)
      else $error("stage one in an illegal mode");
   a_sync_route: assert property (sel_edge[4] && syn[4] |=> int_sync_edge[8] && !int_clk_edge[8])
      else $error("sync pin edge not routed as sync");
endmodule
`default_nettype wire

// ==== verif/ref_src_model.sv ====
// far-side reference sources: two differential pairs and two pin clocks
`timescale 1ns/100ps
`default_nettype none

module ref_src_model (
   // burst request from the bench
   input wire logic go,
   // reference lines into the block
   output logic [1:0] ref_p_pin,
   output logic [1:0] ref_n_pin,
   output logic [1:0] gpio_clk_pin
);
   // lines stand still between bursts; negative pins idle opposite to positive
   initial begin
      ref_p_pin = 2'b00;
      ref_n_pin = 2'b11;
      gpio_clk_pin = 2'b00;
      forever begin
         @(posedge go);
         #2; // keep line changes off the bus clock edges
         // eight cycles at 25 MHz, one fifth of the bus clock, starting 2 ns after a bus clock rising edge
         repeat (8) begin
            #20;
            ref_p_pin = 2'b11;
            ref_n_pin = 2'b00;
            gpio_clk_pin = 2'b11;
            #20;
            ref_p_pin = 2'b00;
            ref_n_pin = 2'b11;
            gpio_clk_pin = 2'b00;
         end
      end
   end
endmodule

`default_nettype wire

// ==== verif/ref_input_stage_analog_multiplier_pll_config_tb.sv ====
// self-checking bench for the pll configuration and input stage block
`timescale 1ns/100ps
`default_nettype none
`include "ref_pll_defs.svh"

module ref_input_stage_analog_multiplier_pll_config_tb;
   import ref_pll_pkg::*;
   // bench-driven inputs
   logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, store_busy = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000, loop_ctrl_level = 12'h800;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hf;
   logic otp_enable = 1'b1, otp_valid = 1'b1, eeprom_enable = 1'b1, eeprom_valid = 1'b1;
   logic [10:0] otp_word = 11'h4c8, eeprom_word = 11'h12c;
   // design outputs and bench state
   logic awready, wready, bvalid, arready, rvalid, pll_doubler_en, pll_locked;
   logic pll_loss_alarm, gpio_status, boot_done;
   logic [1:0] bresp, rresp, rx_bias_pmos, ref_p_pin, ref_n_pin, gpio_clk_pin, r;
   logic [31:0] rdata, d, edges;
   logic [9:0] pll_fb_div;
   boot_src_t boot_src;
   logic [15:0] int_clk_edge, int_sync_edge, nominal_n0, nominal_n1;
   logic [3:0] sync_assoc0, sync_assoc1;
   logic [47:0] nominal_m0, nominal_m1;
   logic [31:0] fbw[4] = '{32'h0001_006c, 32'h0001_006b, 32'h0001_022c, 32'h0003_022d};
   logic [9:0] fbe[4] = '{10'h06c, 10'h06c, 10'h22c, 10'h22c};
   int fails = 0, comparisons = 0, cyc = 0;

   ref_pll_cfg dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .ref_p_pin, .ref_n_pin, .gpio_clk_pin, .loop_ctrl_level,
      .store_busy, .otp_enable, .otp_valid, .otp_word, .eeprom_enable, .eeprom_valid,
      .eeprom_word, .pll_fb_div, .pll_doubler_en, .pll_locked, .pll_loss_alarm,
      .gpio_status, .boot_done, .boot_src, .rx_bias_pmos, .int_clk_edge, .int_sync_edge,
      .sync_assoc0, .sync_assoc1, .nominal_m0, .nominal_n0, .nominal_m1, .nominal_n1);
   ref_src_model src (.go, .ref_p_pin, .ref_n_pin, .gpio_clk_pin);

   // clock, edge vector and hang guard
   always #4 aclk = ~aclk;
   assign edges = {int_sync_edge, int_clk_edge};
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 8000) begin
         fails++;
         summarize();
      end
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rst();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
   endtask

   // handshakes judged on settled values before the edge that takes them
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic aw, w, b;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(negedge aclk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         r = bresp;
         @(posedge aclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) begin
            bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic rd(input logic [11:0] a);
      logic ar, v;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(negedge aclk);
         ar = arvalid && arready;
         v = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ar) arvalid <= 1'b0;
         if (v) begin
            rready <= 1'b0;
            break;
         end
      end
   endtask

   // configure both stages, send one burst, count pulses on two indices
   task automatic run(input logic [31:0] c0, c1, dv, input int ia, ea, ib, eb,
         input logic bs);
      logic [15:0] na, nb;
      na = 16'h0000;
      nb = 16'h0000;
      wr(12'h020, c0);
      wr(12'h030, c1);
      wr(12'h024, dv);
      @(posedge aclk);
      go <= 1'b1;
      repeat (70) begin
         @(negedge aclk);
         na += edges[ia];
         nb += edges[ib];
      end
      @(posedge aclk);
      go <= 1'b0;
      chk(na, ea);
      chk(nb, eb);
      chk(rx_bias_pmos[0], bs);
   endtask

   task automatic summarize();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      rst();
      chk(boot_done, 1'b1);
      chk(pll_fb_div, 10'h0c8);
      chk(pll_doubler_en, 1'b1);
      chk(boot_src, SRC_OTP);
      otp_valid <= 1'b0;
      store_busy <= 1'b1;
      rst();
      wr(`OFS_PLL_CTRL, 32'h0000_0100);
      chk(r, `RESP_ERR);
      chk(pll_fb_div, 10'h1c2);
      chk(boot_done, 1'b0);
      store_busy <= 1'b0;
      repeat (2) @(negedge aclk);
      chk(pll_fb_div, 10'h12c);
      chk(boot_src, SRC_EEPROM);
      rd(12'h024);
      chk(d, 32'h0001_0001);
      $display("test boot done");
      foreach (fbw[i]) begin
         wr(`OFS_PLL_CTRL, fbw[i]);
         chk(r, 2'h0);
         chk(pll_fb_div, fbe[i]);
      end
      chk(pll_doubler_en, 1'b1);
      $display("test divider done");
      loop_ctrl_level <= 12'h8cb;
      repeat (8) @(posedge aclk);
      chk(pll_locked, 1'b1);
      chk(gpio_status, 1'b0);
      loop_ctrl_level <= 12'h8cc;
      repeat (8) @(posedge aclk);
      chk(pll_loss_alarm, 1'b1);
      chk(gpio_status, 1'b1);
      rd(`OFS_PLL_STAT);
      chk(d, 32'h0000_002e);
      loop_ctrl_level <= 12'h735;
      repeat (8) @(posedge aclk);
      wr(`OFS_PLL_STAT, 32'h0000_0004);
      rd(`OFS_PLL_STAT);
      chk(d, 32'h0000_0029);
      $display("test lock done");
      wr(12'h038, 32'h60b9_924d);
      wr(12'h03c, 32'h009e_0006);
      chk(nominal_m1, 48'h0006_60b9_924d);
      chk(nominal_n1, 16'h009e);
      wr(12'h028, 32'h89ab_cdef);
      wr(12'h02c, 32'h0010_1234);
      wstrb <= 4'h2;
      wr(12'h028, 32'h0000_5500);
      wstrb <= 4'hf;
      chk({nominal_n0, nominal_m0}, 64'h0010_1234_89ab_55ef);
      rd(12'hff0);
      chk({r, d}, 34'h2_0000_0000);
      wr(12'h030, 32'h0000_5006);
      rd(12'h030);
      chk(d[1:0], 2'h0);
      chk(sync_assoc1, 4'h5);
      chk(rx_bias_pmos[1], 1'b1);
      wr(12'h020, 32'h0000_0003);
      rd(12'h020);
      chk(d[1:0], 2'h0);
      $display("test registers done");
      run(32'h0000_0020, 32'h0, 32'h0001_0001, 0, 8, 8, 0, 1'b0);
      run(32'h0000_0004, 32'h0, 32'h0001_0001, 0, 4, 8, 0, 1'b1);
      run(32'h0000_0028, 32'h0, 32'h0001_0001, 0, 8, 8, 0, 1'b0);
      run(32'h0000_0065, 32'h0, 32'h0001_0001, 0, 8, 8, 8, 1'b0);
      run(32'h0000_00e1, 32'h0, 32'h0001_0001, 0, 0, 8, 8, 1'b0);
      run(32'h0000_3471, 32'h0, 32'h0001_0001, 8, 0, 24, 8, 1'b0);
      chk(sync_assoc0, 4'h3);
      run(32'h0001_0002, 32'h0, 32'h0001_0001, 8, 8, 0, 4, 1'b0);
      run(32'h0003_0022, 32'h0, 32'h0001_0001, 8, 0, 0, 8, 1'b0);
      run(32'h0000_0020, 32'h0001_0000, 32'h0001_0001, 15, 8, 0, 8, 1'b0);
      $display("test input stages done");
      summarize();
   end
endmodule

`default_nettype wire
